/* File: lpa_annunciator.sv */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
module lpa_annunciator #(
	parameter int unsigned     KEY_DROP_CYC  = lpa_pkg::LPA_KEY_DROP_CYC,
	parameter int unsigned     TRIG_MIN_CYC  = lpa_pkg::LPA_TRIG_MIN_CYC,
	parameter int unsigned     STEP_CYC      = lpa_pkg::LPA_STEP_CYC,
	parameter int unsigned     USER_UNIT_CYC = lpa_pkg::LPA_USER_UNIT_CYC,
	parameter longint unsigned STAGE1_CYC    = lpa_pkg::LPA_STAGE1_CYC
) (
	// Clock and reset
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	// APB slave
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [11:0]                        paddr,
	input  wire logic [31:0]                        pwdata,
	output logic      [31:0]                        prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	// Internal logic operands and self-test sources
	input  wire logic [lpa_pkg::LPA_N_OPS-1:0]      op_in,
	input  wire logic [lpa_pkg::LPA_N_MAJOR-1:0]    major_alarm,
	input  wire logic [lpa_pkg::LPA_N_MINOR-1:0]    minor_alarm,
	input  wire logic                               remote_reset,
	// Faceplate key pins
	input  wire logic                               reset_key_pin,
	input  wire logic [lpa_pkg::LPA_N_CTRL-1:0]     control_key_pin,
	input  wire logic [lpa_pkg::LPA_N_USER-1:0]     user_key_pin,
	// Lamps
	output logic      [lpa_pkg::LPA_N_LAMPS-1:0]    lamp,
	output logic                                    lamp_test_active,
	output logic                                    lamp_test_event,
	// Key operands and events
	output logic      [lpa_pkg::LPA_N_CTRL-1:0]     control_key_asserted,
	output logic      [lpa_pkg::LPA_N_CTRL-1:0]     key_event,
	output logic      [lpa_pkg::LPA_N_USER-1:0]     user_key_asserted,
	// Self-test reporting
	output logic      [lpa_pkg::LPA_N_ALARM-1:0]    alarm_operand,
	output logic      [lpa_pkg::LPA_N_ALARM-1:0]    alarm_event,
	output logic                                    any_minor_alarm,
	output logic                                    any_self_test
);
	import lpa_pkg::*;

	function automatic logic op_pick(input logic [LPA_N_OPS-1:0] ops, input logic [LPA_OP_W-1:0] idx);
		op_pick = ops[idx];
	endfunction : op_pick

	// Configuration
	logic [LPA_CTRL_W-1:0]  ctrl;
	logic [LPA_OP_W-1:0]    lamp_test_trigger_source;
	logic [LPA_OP_W-1:0]    trip_sel;
	logic [LPA_OP_W-1:0]    alarm_sel;
	logic [LPA_OP_W-1:0]    reset_sel;
	logic [LPA_N_MINOR-1:0] minor_en;
	logic [LPA_N_IND-1:0]   indicator_latch_select;
	logic [LPA_OP_W-1:0]    ind_sel [LPA_N_IND];
	logic [7:0]             user_key_release_delay [LPA_N_USER];
	logic                   sw_reset;

	// Indicator state
	logic [LPA_N_IND-1:0]   ind_op;
	logic [LPA_N_IND-1:0]   ind_latched;
	logic [LPA_N_IND-1:0]   ind_true;
	logic [LPA_N_LAMPS-1:0] lamp_true;
	logic                   clear_req;

	// Lamp test
	lpa_lt_state_t          lt_state;
	logic [LPA_TMR_W-1:0]   lt_tmr;
	logic [LPA_LAMP_W-1:0]  lt_idx;
	logic [LPA_TMR_W-1:0]   trig_cnt;
	logic                   trig_q;
	logic                   trig_q_d;
	logic                   trig_rise;
	logic [LPA_N_LAMPS-1:0] lt_onehot;

	// Pins and keys
	logic [LPA_N_KEYS:0]    pin_s1;
	logic [LPA_N_KEYS:0]    pin_s2;
	lpa_key_if              kif ();

	// Bus
	logic                   setup;
	logic [31:0]            rd_next;
	logic                   err_next;
	logic                   wr_en;

	////////////////////////////////////////////////////////////
	// APB slave: zero wait, read data captured in setup cycle
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pwrite;
	assign pready = 1'b1;

	always_comb begin
		rd_next  = LPA_ZERO;
		err_next = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			err_next = 1'b1;
		end else if (paddr >= LPA_REG_IND_SEL && paddr < LPA_REG_IND_SEL + 12'(4 * LPA_N_IND)) begin
			rd_next[LPA_OP_W-1:0] = ind_sel[paddr[7:2]];
		end else if (paddr >= LPA_REG_USER_DLY && paddr < LPA_REG_USER_DLY + 12'(4 * LPA_N_USER)) begin
			rd_next[7:0] = user_key_release_delay[paddr[5:2]];
		end else begin
			unique case (paddr)
				LPA_REG_CTRL:     rd_next[LPA_CTRL_W-1:0] = ctrl;
				LPA_REG_TEST_SRC: rd_next[LPA_OP_W-1:0] = lamp_test_trigger_source;
				LPA_REG_OP_SEL:   rd_next[23:0] = {reset_sel, alarm_sel, trip_sel};
				LPA_REG_MINOR_EN: rd_next[LPA_N_MINOR-1:0] = minor_en;
				LPA_REG_LATCH_LO: rd_next = indicator_latch_select[31:0];
				LPA_REG_LATCH_HI: rd_next[15:0] = indicator_latch_select[47:32];
				LPA_REG_STATUS:   rd_next[19:0] = {any_self_test, any_minor_alarm, lamp_test_active,
					1'(lt_state == LPA_LT_SWEEP_OFF), alarm_operand};
				LPA_REG_IND_LO:   rd_next = ind_true[31:0];
				LPA_REG_IND_HI:   rd_next[15:0] = ind_true[47:32];
				default:          err_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= LPA_ZERO;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? LPA_ZERO : rd_next;
			pslverr <= err_next;
		end
	end

	////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl                     <= '0;
			lamp_test_trigger_source <= '0;
			trip_sel                 <= '0;
			alarm_sel                <= '0;
			reset_sel                <= '0;
			minor_en                 <= '0;
			indicator_latch_select   <= '0;
			sw_reset                 <= 1'b0;
			for (int i = 0; i < LPA_N_IND; i++) begin
				ind_sel[i] <= '0;
			end
			for (int i = 0; i < LPA_N_USER; i++) begin
				user_key_release_delay[i] <= '0;
			end
		end else begin
			sw_reset <= wr_en && !err_next && paddr == LPA_REG_CTRL && pwdata[LPA_CTRL_RESET];
			if (wr_en && !err_next) begin
				if (paddr >= LPA_REG_IND_SEL && paddr < LPA_REG_IND_SEL + 12'(4 * LPA_N_IND)) begin
					ind_sel[paddr[7:2]] <= pwdata[LPA_OP_W-1:0];
				end else if (paddr >= LPA_REG_USER_DLY && paddr < LPA_REG_USER_DLY + 12'(4 * LPA_N_USER)) begin
					user_key_release_delay[paddr[5:2]] <= pwdata[7:0];
				end else begin
					unique case (paddr)
						LPA_REG_CTRL:     ctrl <= pwdata[LPA_CTRL_W-1:0];
						LPA_REG_TEST_SRC: lamp_test_trigger_source <= pwdata[LPA_OP_W-1:0];
						LPA_REG_OP_SEL: begin
							trip_sel  <= pwdata[LPA_SEL_TRIP +: LPA_OP_W];
							alarm_sel <= pwdata[LPA_SEL_ALARM +: LPA_OP_W];
							reset_sel <= pwdata[LPA_SEL_RESET +: LPA_OP_W];
						end
						LPA_REG_MINOR_EN: minor_en <= pwdata[LPA_N_MINOR-1:0];
						LPA_REG_LATCH_LO: indicator_latch_select[31:0] <= pwdata;
						LPA_REG_LATCH_HI: indicator_latch_select[47:32] <= pwdata[15:0];
						default: ;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Pin synchronisers: reset key, control keys, user keys
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {reset_key_pin, user_key_pin, control_key_pin};
			pin_s2 <= pin_s1;
		end
	end

	////////////////////////////////////////////////////////////
	// Indicators
	always_comb begin
		for (int i = 0; i < LPA_N_IND; i++) begin
			ind_op[i] = op_pick(op_in, ind_sel[i]);
		end
	end

	// Targets stay put while the test runs
	assign clear_req = (pin_s2[LPA_N_KEYS] || remote_reset || sw_reset || op_pick(op_in, reset_sel))
		&& !lamp_test_active;

	// New operand set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_latched <= '0;
		end else begin
			ind_latched <= (ind_latched & ~{LPA_N_IND{clear_req}}) | ind_op;
		end
	end

	assign ind_true  = (indicator_latch_select & ind_latched) | (~indicator_latch_select & ind_op);
	assign lamp_true = {user_key_asserted, ind_true, op_pick(op_in, alarm_sel), op_pick(op_in, trip_sel)};

	////////////////////////////////////////////////////////////
	// Lamp test trigger qualification
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_cnt <= '0;
			trig_q   <= 1'b0;
			trig_q_d <= 1'b0;
		end else begin
			trig_q_d <= trig_q;
			if (!(ctrl[LPA_CTRL_TEST_EN] && op_pick(op_in, lamp_test_trigger_source))) begin
				trig_cnt <= '0;
				trig_q   <= 1'b0;
			end else if (trig_cnt < LPA_TMR_W'(TRIG_MIN_CYC - 1)) begin
				trig_cnt <= trig_cnt + LPA_TMR_W'(1);
			end else begin
				trig_q <= 1'b1;
			end
		end
	end

	assign trig_rise = trig_q && !trig_q_d;

	////////////////////////////////////////////////////////////
	// Lamp test sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lt_state        <= LPA_LT_IDLE;
			lt_tmr          <= '0;
			lt_idx          <= '0;
			lamp_test_event <= 1'b0;
		end else begin
			lamp_test_event <= 1'b0;
			unique case (lt_state)
				LPA_LT_IDLE: begin
					lt_tmr <= '0;
					if (trig_rise) begin
						lt_state        <= LPA_LT_ALL_ON;
						lamp_test_event <= 1'b1;
					end
				end
				LPA_LT_ALL_ON: begin
					if (!trig_q) begin
						lt_state <= LPA_LT_SWEEP_ON;
						lt_tmr   <= '0;
						lt_idx   <= '0;
					end else if (lt_tmr == LPA_TMR_W'(STAGE1_CYC - 1)) begin
						lt_state <= LPA_LT_IDLE;
					end else begin
						lt_tmr <= lt_tmr + LPA_TMR_W'(1);
					end
				end
				LPA_LT_SWEEP_ON, LPA_LT_SWEEP_OFF: begin
					if (trig_rise) begin
						lt_state <= LPA_LT_IDLE;
					end else if (lt_tmr == LPA_TMR_W'(STEP_CYC - 1)) begin
						lt_tmr <= '0;
						if (lt_idx == LPA_LAMP_W'(LPA_N_LAMPS - 1)) begin
							lt_idx   <= '0;
							lt_state <= (lt_state == LPA_LT_SWEEP_ON) ? LPA_LT_SWEEP_OFF : LPA_LT_IDLE;
						end else begin
							lt_idx <= lt_idx + LPA_LAMP_W'(1);
						end
					end else begin
						lt_tmr <= lt_tmr + LPA_TMR_W'(1);
					end
				end
			endcase
		end
	end

	assign lamp_test_active = lt_state != LPA_LT_IDLE;
	assign lt_onehot        = LPA_N_LAMPS'(1) << lt_idx;

	// True state keeps updating underneath the test pattern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lamp <= '0;
		end else begin
			unique case (lt_state)
				LPA_LT_IDLE:      lamp <= lamp_true;
				LPA_LT_ALL_ON:    lamp <= '1;
				LPA_LT_SWEEP_ON:  lamp <= lt_onehot;
				LPA_LT_SWEEP_OFF: lamp <= ~lt_onehot;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// Self-test alarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_operand   <= '0;
			alarm_event     <= '0;
			any_minor_alarm <= 1'b0;
			any_self_test   <= 1'b0;
		end else begin
			alarm_operand   <= {minor_alarm & minor_en, major_alarm};
			alarm_event     <= {minor_alarm & minor_en, major_alarm} & ~alarm_operand;
			any_minor_alarm <= |(minor_alarm & minor_en);
			any_self_test   <= (|major_alarm) || (|(minor_alarm & minor_en));
		end
	end

	////////////////////////////////////////////////////////////
	// Faceplate keys; no password stage in this path
	always_comb begin
		kif.key_raw = pin_s2[LPA_N_KEYS-1:0];
		for (int i = 0; i < LPA_N_KEYS; i++) begin
			kif.key_enable[i] = 1'b1;
			if (i < LPA_N_STD_CTRL) begin
				kif.key_enable[i] = !ctrl[LPA_CTRL_BRK_KEYS];
			end else begin
				kif.key_enable[i] = ctrl[LPA_CTRL_FITTED];
			end
			if (i < LPA_N_CTRL) begin
				kif.drop_cyc[i] = LPA_CNT_W'(KEY_DROP_CYC);
			end else begin
				kif.drop_cyc[i] = LPA_CNT_W'(user_key_release_delay[i - LPA_N_CTRL] * USER_UNIT_CYC);
			end
		end
	end

	lpa_key_cond u_keys (
		.pclk    (pclk),
		.presetn (presetn),
		.kif     (kif.cond)
	);

	assign control_key_asserted = kif.asserted[LPA_N_CTRL-1:0];
	assign user_key_asserted    = kif.asserted[LPA_N_KEYS-1:LPA_N_CTRL];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_event <= '0;
		end else begin
			key_event <= kif.press[LPA_N_CTRL-1:0] & {LPA_N_CTRL{ctrl[LPA_CTRL_LOG_EN]}};
		end
	end

endmodule : lpa_annunciator

/* File: lpa_annunciator_monitor.sv */
`timescale 1ns/100ps
module lpa_annunciator_monitor (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Sources and results
	input wire logic [7:0]  major_alarm,
	input wire logic [7:0]  minor_alarm,
	input wire logic [61:0] lamp,
	input wire logic        lamp_test_active,
	input wire logic [6:0]  control_key_asserted,
	input wire logic [6:0]  key_event,
	input wire logic [15:0] alarm_operand,
	input wire logic [15:0] alarm_event
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	a_major_always: assert property ($past(presetn) |-> alarm_operand[7:0] == $past(major_alarm))
		else $error("major alarm not reported");
	a_minor_gated: assert property ($past(presetn) |-> (alarm_operand[15:8] & ~$past(minor_alarm)) == 8'h00)
		else $error("minor alarm without source");
	a_event_on_rise: assert property ($past(presetn) |-> alarm_event == (alarm_operand & ~$past(alarm_operand)))
		else $error("alarm event not on rise");
	a_test_all_on: assert property ($rose(lamp_test_active) |-> ##[1:2] (lamp == {62{1'b1}}))
		else $error("lamps not all on at test start");
	a_one_key: assert property ($onehot0(key_event))
		else $error("two key events at once");
	a_event_pulse: assert property (|key_event |=> (key_event & $past(key_event)) == 7'h00)
		else $error("key event longer than one cycle");
	a_key_dropout: assert property ($rose(|control_key_asserted) |-> (|control_key_asserted) [*8])
		else $error("key operand dropped too soon");
	a_refused_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	// Main scenarios reached
	c_test: cover property ($rose(lamp_test_active));
	c_key: cover property ($rose(|key_event));
	c_minor: cover property ($rose(alarm_operand[8]));
endmodule : lpa_annunciator_monitor

bind lpa_annunciator lpa_annunciator_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pslverr,
	.major_alarm, .minor_alarm, .lamp, .lamp_test_active, .control_key_asserted, .key_event, .alarm_operand,
	.alarm_event);

/* File: lpa_annunciator_tb_top.sv */
`timescale 1ns/100ps
module lpa_annunciator_tb_top;
	import lpa_pkg::*;
	localparam int KD = 20;
	logic        pclk, presetn, psel, penable, pwrite, remote_reset, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, lamp_test_active, lamp_test_event, any_minor_alarm, any_self_test, reset_key_pin;
	logic [LPA_N_OPS-1:0]  op_in;
	logic [7:0]  major_alarm, minor_alarm;
	logic [61:0] lamp;
	logic [6:0]  control_key_pin, control_key_asserted, key_event;
	logic [11:0] user_key_pin, user_key_asserted;
	logic [15:0] alarm_operand, alarm_event;
	int          mismatches = 0, checks_done = 0, cyc = 0, evn = 0, tev = 0;
	lpa_annunciator #(.KEY_DROP_CYC(KD), .TRIG_MIN_CYC(5), .STEP_CYC(4), .USER_UNIT_CYC(3), .STAGE1_CYC(200)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_in,
		.major_alarm, .minor_alarm, .remote_reset, .reset_key_pin, .control_key_pin, .user_key_pin, .lamp,
		.lamp_test_active, .lamp_test_event, .control_key_asserted, .key_event, .user_key_asserted,
		.alarm_operand, .alarm_event, .any_minor_alarm, .any_self_test);
	lpa_faceplate_model u_keys (.pclk, .reset_key_pin, .control_key_pin, .user_key_pin);
	always #5 pclk = ~pclk;
	always @(posedge pclk) evn <= evn + $countones(key_event);
	always @(posedge pclk) tev <= tev + int'(lamp_test_event);
	// Hang guard, well above the thousand or so cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task end_of_test;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// One edge of idle first, so psel is never driven twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	////////////////////////////////////////////////////////////////
	task t_regs;
		apb(1'b0, LPA_REG_CTRL, LPA_ZERO);
		chk({rerr, rdat}, {1'b0, LPA_ZERO});
		apb(1'b0, 12'h300, LPA_ZERO);
		chk({rerr, rdat}, {1'b1, LPA_ZERO});
		apb(1'b1, LPA_REG_OP_SEL, 32'h000A_0807);
		apb(1'b0, LPA_REG_OP_SEL, LPA_ZERO);
		chk(rdat, 32'h000A_0807);
		$display("t_regs done");
	endtask : t_regs
	task t_ind;
		apb(1'b1, LPA_REG_IND_SEL, 32'h0000_0005);
		apb(1'b1, LPA_REG_IND_SEL + 12'h0BC, 32'h0000_0006);
		apb(1'b1, LPA_REG_LATCH_HI, 32'h0000_8000);
		op_in[7:5] <= 3'b111;
		repeat (3) @(posedge pclk);
		chk({lamp[49], lamp[2:0]}, 4'b1101);
		op_in[7:5] <= 3'b000;
		repeat (3) @(posedge pclk);
		chk({lamp[49], lamp[2]}, 2'b10);
		apb(1'b0, LPA_REG_IND_HI, LPA_ZERO);
		chk(rdat, 32'h0000_8000);
		for (int s = 0; s < 4; s++) begin
			if (s == 0) op_in[10] <= 1'b1;
			else if (s == 1) remote_reset <= 1'b1;
			else if (s == 2) u_keys.hold(19);
			else apb(1'b1, LPA_REG_CTRL, 32'h0000_0100);
			repeat (6) @(posedge pclk);
			chk(lamp[49], 1'b0);
			op_in[10] <= 1'b0;
			remote_reset <= 1'b0;
			u_keys.release_all();
			op_in[6] <= 1'b1;
			repeat (6) @(posedge pclk);
			op_in[6] <= 1'b0;
		end
		$display("t_ind done");
	endtask : t_ind
	task t_alarm;
		apb(1'b1, LPA_REG_MINOR_EN, 32'h0000_0055);
		major_alarm <= 8'hFF;
		minor_alarm <= 8'hFF;
		repeat (3) @(posedge pclk);
		chk({any_self_test, any_minor_alarm, alarm_operand}, {2'b11, 16'h55FF});
		apb(1'b0, LPA_REG_STATUS, LPA_ZERO);
		chk(rdat, 32'h000C_55FF);
		major_alarm <= 8'h00;
		minor_alarm <= 8'hAA;
		repeat (3) @(posedge pclk);
		chk({any_self_test, any_minor_alarm, alarm_operand}, {2'b00, 16'h0000});
		minor_alarm <= 8'h00;
		$display("t_alarm done");
	endtask : t_alarm
	task t_keys;
		int i;
		int e0;
		apb(1'b1, LPA_REG_CTRL, 32'h0000_000E);
		u_keys.hold(0);
		u_keys.hold(1);
		u_keys.hold(2);
		repeat (8) @(posedge pclk);
		chk(control_key_asserted, 7'h00);
		u_keys.release_all();
		e0 = evn;
		u_keys.hold(3);
		repeat (5) @(posedge pclk);
		u_keys.hold(4);
		repeat (5) @(posedge pclk);
		chk(control_key_asserted, 7'h08);
		u_keys.release_all();
		for (i = 0; i < 100 && control_key_asserted[3] === 1'b1; i++) @(posedge pclk);
		chk(i >= KD && i <= KD + 5, 1'b1);
		chk(64'(evn - e0), 64'd1);
		apb(1'b1, LPA_REG_CTRL, 32'h0000_0008);
		e0 = evn;
		u_keys.hold(5);
		repeat (6) @(posedge pclk);
		chk(control_key_asserted, 7'h20);
		u_keys.release_all();
		repeat (KD + 8) @(posedge pclk);
		chk(64'(evn - e0), 64'd0);
		apb(1'b1, LPA_REG_USER_DLY, 32'h0000_0002);
		u_keys.hold(7);
		repeat (6) @(posedge pclk);
		chk({user_key_asserted, lamp[50]}, 13'h0003);
		u_keys.release_all();
		repeat (4) @(posedge pclk);
		chk(user_key_asserted, 12'h001);
		repeat (8) @(posedge pclk);
		chk(user_key_asserted, 12'h000);
		$display("t_keys done");
	endtask : t_keys
	task t_lamp;
		int i;
		apb(1'b1, LPA_REG_TEST_SRC, 32'h0000_0009);
		apb(1'b1, LPA_REG_CTRL, 32'h0000_0001);
		for (int r = 0; r < 2; r++) begin
			op_in[5] <= 1'b0;
			op_in[9] <= 1'b1;
			repeat (30) @(posedge pclk);
			chk({lamp_test_active, lamp}, {1'b1, {62{1'b1}}});
			op_in[5] <= 1'b1;
			op_in[9] <= 1'b0;
			repeat (4) @(posedge pclk);
			chk(64'($countones(lamp)), 64'd1);
			if (r == 0) begin
				for (i = 0; i < 600 && $countones(lamp) != 61; i++) @(posedge pclk);
				chk(64'($countones(lamp)), 64'd61);
				for (i = 0; i < 600 && lamp_test_active !== 1'b0; i++) @(posedge pclk);
				repeat (2) @(posedge pclk);
				chk({lamp_test_active, lamp[2]}, 2'b01);
			end else begin
				op_in[9] <= 1'b1;
				repeat (10) @(posedge pclk);
				chk(lamp_test_active, 1'b0);
				op_in[9] <= 1'b0;
			end
			repeat (4) @(posedge pclk);
		end
		op_in[9] <= 1'b1;
		repeat (220) @(posedge pclk);
		chk({lamp_test_active, lamp[2]}, 2'b01);
		op_in[9] <= 1'b0;
		chk(64'(tev), 64'd3);
		$display("t_lamp done");
	endtask : t_lamp
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, remote_reset} = 4'h0;
		paddr = 12'h000;
		pwdata = LPA_ZERO;
		op_in = '0;
		major_alarm = 8'h00;
		minor_alarm = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_ind();
		t_alarm();
		t_keys();
		t_lamp();
		end_of_test();
	end
endmodule : lpa_annunciator_tb_top

/* File: lpa_faceplate_model.sv */
`timescale 1ns/100ps
module lpa_faceplate_model (
	// Clock
	input  wire logic        pclk,
	// Key pins, active high
	output logic             reset_key_pin,
	output logic [6:0]       control_key_pin,
	output logic [11:0]      user_key_pin
);
	// Index 0..6 control keys, 7..18 user keys, 19 reset key
	logic [19:0] pins = '0;
	assign {reset_key_pin, user_key_pin, control_key_pin} = pins;
	////////////////////////////////////////////////////////////////
	// Contacts move only just after an edge, never mid-cycle
	task hold(input int k);
		@(posedge pclk);
		pins[k] <= 1'b1;
	endtask : hold
	task release_all;
		@(posedge pclk);
		pins <= '0;
	endtask : release_all
endmodule : lpa_faceplate_model

/* File: lpa_key_cond.sv */
`timescale 1ns/100ps
module lpa_key_cond (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Key group
	lpa_key_if.cond  kif
);
	import lpa_pkg::*;

	logic                  owned;
	logic [LPA_KEY_W-1:0]  owner;
	logic [LPA_N_KEYS-1:0] held;
	logic [LPA_N_KEYS-1:0] held_d;
	logic [LPA_CNT_W-1:0]  cnt [LPA_N_KEYS];
	logic [LPA_N_KEYS-1:0] avail;

	function automatic logic [LPA_KEY_W-1:0] lpa_first(input logic [LPA_N_KEYS-1:0] v);
		lpa_first = '0;
		for (int i = LPA_N_KEYS - 1; i >= 0; i--) begin
			if (v[i]) begin
				lpa_first = LPA_KEY_W'(i);
			end
		end
	endfunction : lpa_first

	assign avail = kif.key_raw & kif.key_enable;

	////////////////////////////////////////////////////////////
	// Only the owning key counts; others wait for its release
	always_comb begin
		held = '0;
		if (owned) begin
			held[owner] = avail[owner];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owned <= 1'b0;
			owner <= '0;
		end else if (!owned && (|avail)) begin
			owned <= 1'b1;
			owner <= lpa_first(avail);
		end else if (owned && !avail[owner]) begin
			owned <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// Dropout stretch, reloaded while held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LPA_N_KEYS; i++) begin
				cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < LPA_N_KEYS; i++) begin
				if (held[i]) begin
					cnt[i] <= kif.drop_cyc[i];
				end else if (cnt[i] != '0) begin
					cnt[i] <= cnt[i] - LPA_CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_d       <= '0;
			kif.asserted <= '0;
			kif.press    <= '0;
		end else begin
			held_d <= held;
			for (int i = 0; i < LPA_N_KEYS; i++) begin
				kif.asserted[i] <= held[i] || (cnt[i] != '0);
			end
			kif.press <= held & ~held_d;
		end
	end

endmodule : lpa_key_cond

/* File: lpa_key_if.sv */
`timescale 1ns/100ps
interface lpa_key_if;
	import lpa_pkg::*;
	logic [LPA_N_KEYS-1:0] key_raw;
	logic [LPA_N_KEYS-1:0] key_enable;
	logic [LPA_CNT_W-1:0]  drop_cyc [LPA_N_KEYS];
	logic [LPA_N_KEYS-1:0] asserted;
	logic [LPA_N_KEYS-1:0] press;
	modport owner (output key_raw, output key_enable, output drop_cyc, input asserted, input press);
	modport cond  (input key_raw, input key_enable, input drop_cyc, output asserted, output press);
endinterface : lpa_key_if

/* File: lpa_pkg.sv */
package lpa_pkg;

	// Clock and sizes
	localparam int unsigned LPA_CLK_HZ     = 100_000_000;
	localparam int unsigned LPA_CYC_PER_MS = LPA_CLK_HZ / 1000;
	localparam int unsigned LPA_N_IND      = 48;
	localparam int unsigned LPA_N_CTRL     = 7;
	localparam int unsigned LPA_N_STD_CTRL = 3;
	localparam int unsigned LPA_N_USER     = 12;
	localparam int unsigned LPA_N_KEYS     = LPA_N_CTRL + LPA_N_USER;
	localparam int unsigned LPA_N_OPS      = 256;
	localparam int unsigned LPA_OP_W       = 8;
	localparam int unsigned LPA_N_MAJOR    = 8;
	localparam int unsigned LPA_N_MINOR    = 8;
	localparam int unsigned LPA_N_ALARM    = LPA_N_MAJOR + LPA_N_MINOR;
	localparam int unsigned LPA_N_LAMPS    = 2 + LPA_N_IND + LPA_N_USER;
	localparam int unsigned LPA_LAMP_W     = 6;
	localparam int unsigned LPA_CNT_W      = 28;
	localparam int unsigned LPA_TMR_W      = 33;
	localparam int unsigned LPA_KEY_W      = 5;

	// Times in their own units
	localparam int unsigned LPA_T_KEY_DROP_MS  = 100;
	localparam int unsigned LPA_T_TRIG_MIN_MS  = 250;
	localparam int unsigned LPA_T_STEP_MS      = 1000;
	localparam int unsigned LPA_T_STAGE1_MS    = 60000;
	localparam int unsigned LPA_T_USER_UNIT_MS = 10;

	// Derived cycle counts
	localparam int unsigned LPA_KEY_DROP_CYC  = LPA_T_KEY_DROP_MS * LPA_CYC_PER_MS;
	localparam int unsigned LPA_TRIG_MIN_CYC  = LPA_T_TRIG_MIN_MS * LPA_CYC_PER_MS;
	localparam int unsigned LPA_STEP_CYC      = LPA_T_STEP_MS * LPA_CYC_PER_MS;
	localparam int unsigned LPA_USER_UNIT_CYC = LPA_T_USER_UNIT_MS * LPA_CYC_PER_MS;
	localparam longint unsigned LPA_STAGE1_CYC = longint'(LPA_T_STAGE1_MS) * longint'(LPA_CYC_PER_MS);

	// Register map, byte addresses
	localparam logic [11:0] LPA_REG_CTRL     = 12'h000;
	localparam logic [11:0] LPA_REG_TEST_SRC = 12'h004;
	localparam logic [11:0] LPA_REG_OP_SEL   = 12'h008;
	localparam logic [11:0] LPA_REG_MINOR_EN = 12'h00C;
	localparam logic [11:0] LPA_REG_LATCH_LO = 12'h010;
	localparam logic [11:0] LPA_REG_LATCH_HI = 12'h014;
	localparam logic [11:0] LPA_REG_STATUS   = 12'h018;
	localparam logic [11:0] LPA_REG_IND_LO   = 12'h01C;
	localparam logic [11:0] LPA_REG_IND_HI   = 12'h020;
	localparam logic [11:0] LPA_REG_IND_SEL  = 12'h100;
	localparam logic [11:0] LPA_REG_USER_DLY = 12'h200;

	// Control register fields
	localparam int unsigned LPA_CTRL_TEST_EN  = 0;
	localparam int unsigned LPA_CTRL_BRK_KEYS = 1;
	localparam int unsigned LPA_CTRL_LOG_EN   = 2;
	localparam int unsigned LPA_CTRL_FITTED   = 3;
	localparam int unsigned LPA_CTRL_RESET    = 8;
	localparam int unsigned LPA_CTRL_W        = 4;

	// Operand select field positions
	localparam int unsigned LPA_SEL_TRIP  = 0;
	localparam int unsigned LPA_SEL_ALARM = 8;
	localparam int unsigned LPA_SEL_RESET = 16;

	// Reset values
	localparam logic [31:0] LPA_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		LPA_LT_IDLE,
		LPA_LT_ALL_ON,
		LPA_LT_SWEEP_ON,
		LPA_LT_SWEEP_OFF
	} lpa_lt_state_t;

endpackage : lpa_pkg
